/* rtl/fcld_pkg.sv */
// Shared constants, field layouts and types of the four-channel LED dimming control
package fcld_pkg;
  // Clock rate of pclk
  localparam int CLK_HZ = 20_000_000;
  // PWM steps per period
  localparam int PWM_STEPS = 4095;
  // Supported PWM rates in Hz
  localparam int F_SEL0_HZ = 220;
  localparam int F_SEL1_HZ = 250;
  localparam int F_SEL2_HZ = 280;
  localparam int F_SEL3_HZ = 330;
  // Times as printed
  localparam int FLT_T_MS = 4;
  localparam int HICCUP_T_MS = 1;
  localparam int DET_T_US = 32;
  localparam int STAGGER_T_US = 160;
  localparam int SCL_TO_MIN_MS = 25;
  // Times as clock cycles
  localparam int FLT_CYC = FLT_T_MS * (CLK_HZ / 1000);
  localparam int HICCUP_CYC = HICCUP_T_MS * (CLK_HZ / 1000);
  localparam int DET_CYC = DET_T_US * (CLK_HZ / 1_000_000);
  localparam int STAGGER_CYC = STAGGER_T_US * (CLK_HZ / 1_000_000);
  localparam int SCL_TO_CYC = SCL_TO_MIN_MS * (CLK_HZ / 1000);
  // Width of the long counters
  localparam int CW = 20;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_AMP0 = 8'h10;
  localparam logic [7:0] REG_DLO0 = 8'h20;
  localparam logic [7:0] REG_DHI0 = 8'h30;
  // Control register: enables off, 250 Hz selected
  localparam logic [11:0] CTRL_RST = 12'h004;

  // Control register layout, bit 11 downward
  typedef struct packed {
    logic [3:0] ch_en;
    logic [1:0] rsvd;
    logic [1:0] short_threshold_select;
    logic [1:0] pwm_freq_select;
    logic phase_stagger_enable;
    logic glob_en;
  } fcld_ctrl_t;

  // Sink comparators of the four channels
  typedef struct packed {
    logic [3:0] open_cmp;
    logic [3:0] short_cmp;
  } fcld_sense_t;

  // Per-channel fault sequence
  typedef enum logic [1:0] {F_RUN, F_OFF, F_DET} fcld_fst_t;

  // Whole state of the block
  typedef struct packed {
    logic [12:0] sy1;
    logic [12:0] sy2;
    logic active;
    logic therm;
    logic pready;
    logic pslverr;
    logic rel;
    logic [31:0] prdata;
    fcld_ctrl_t ctrl;
    logic [3:0][5:0] amp;
    logic [3:0][3:0] dlo;
    logic [3:0][11:0] duty;
    logic [4:0] pc;
    logic [11:0] bc;
    fcld_fst_t [3:0] fst;
    logic [3:0] kind;
    logic [3:0][CW-1:0] ocnt;
    logic [3:0][CW-1:0] scnt;
    logic [CW-1:0] tcnt;
    logic [3:0] gate;
  } fcld_st_t;

  // Prescaler from pclk to one PWM step, rounded to nearest
  function automatic logic [4:0] pwm_presc(input logic [1:0] sel);
    int f;
    case (sel)
      2'b00: f = F_SEL0_HZ;
      2'b01: f = F_SEL1_HZ;
      2'b10: f = F_SEL2_HZ;
      default: f = F_SEL3_HZ;
    endcase
    return 5'((CLK_HZ + (f * PWM_STEPS) / 2) / (f * PWM_STEPS));
  endfunction : pwm_presc

  // Stagger delay expressed in PWM steps
  function automatic logic [11:0] phase_off(input logic [1:0] sel);
    int p;
    p = int'(pwm_presc(sel));
    return 12'((STAGGER_CYC + p / 2) / p);
  endfunction : phase_off
endpackage : fcld_pkg

/* rtl/fcld_top.sv */
// APB-controlled four-channel LED dimming, fault timing and bus timeout logic
//
// Local design decisions: the address map and the APB interface to the registers.
module fcld_top
  import fcld_pkg::*;
#(
  parameter int FLT_CYCLES = FLT_CYC,
  parameter int HICCUP_CYCLES = HICCUP_CYC,
  parameter int SCL_TO_CYCLES = SCL_TO_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic uvlo_ok,
  input wire logic en_pin,
  input wire fcld_sense_t sense,
  input wire logic temp_hot,
  input wire logic temp_cool,
  input wire logic scl_in,
  output logic [3:0] ch_gate,
  output logic [3:0][5:0] ch_amp,
  output logic [1:0] short_thr,
  output logic bus_release
);

  // Registered and next state
  fcld_st_t st_q;
  fcld_st_t st_d;

  // Next-state logic for the whole block
  always_comb begin
    logic wr;
    logic setup;
    logic [1:0] ch;
    logic [31:0] rdv;
    logic rerr;
    logic [12:0] t;
    logic [11:0] off;
    logic [3:0] pwm;
    logic ch_ok;
    logic [4:0] presc;
    wr = psel & penable & pwrite & st_q.pready;
    setup = psel & ~penable;
    ch = paddr[3:2];
    rdv = 32'h0;
    rerr = 1'b0;
    pwm = 4'h0;
    t = 13'h0;
    ch_ok = 1'b0;
    presc = pwm_presc(st_q.ctrl.pwm_freq_select);
    off = st_q.ctrl.phase_stagger_enable ? phase_off(st_q.ctrl.pwm_freq_select) : 12'h0;
    st_d = st_q;

    // Two-stage synchronisers for all pins except the APB inputs
    st_d.sy1 = {uvlo_ok, en_pin, sense.open_cmp, sense.short_cmp, temp_hot, temp_cool, scl_in};
    st_d.sy2 = st_q.sy1;
    // Start-up only with supply and enable pin both good
    st_d.active = st_q.sy2[12] & st_q.sy2[11];

    // Zero-wait slave: ready from the first cycle after reset
    st_d.pready = 1'b1;
    // Address decode for reads and writes
    if (paddr == REG_CTRL) begin
      rdv = {20'h0, st_q.ctrl};
      if (wr) begin
        st_d.ctrl = fcld_ctrl_t'(pwdata[11:0]);
        st_d.ctrl.rsvd = 2'b00;
      end
    end else if (paddr == REG_STAT) begin
      // Read-only fault and state view
      for (int k = 0; k < 4; k++) begin
        rdv[k] = (st_q.fst[k] != F_RUN) & ~st_q.kind[k];
        rdv[k + 4] = (st_q.fst[k] != F_RUN) & st_q.kind[k];
      end
      rdv[8] = st_q.therm;
      rdv[9] = st_q.active;
    end else if (paddr[7:4] == REG_AMP0[7:4] && paddr[1:0] == 2'b00) begin
      rdv = {26'h0, st_q.amp[ch]};
      if (wr) begin
        st_d.amp[ch] = pwdata[5:0];
      end
    end else if (paddr[7:4] == REG_DLO0[7:4] && paddr[1:0] == 2'b00) begin
      // Low nibble waits for the high byte
      rdv = {28'h0, st_q.dlo[ch]};
      if (wr) begin
        st_d.dlo[ch] = pwdata[3:0];
      end
    end else if (paddr[7:4] == REG_DHI0[7:4] && paddr[1:0] == 2'b00) begin
      // High byte write moves the whole code to the generator
      rdv = {24'h0, st_q.duty[ch][11:4]};
      if (wr) begin
        st_d.duty[ch] = {pwdata[7:0], st_q.dlo[ch]};
      end
    end else begin
      // Unmapped address answers with an error
      rerr = 1'b1;
    end
    // Read data and error captured in the setup cycle
    if (setup) begin
      st_d.prdata = pwrite ? 32'h0 : rdv;
      st_d.pslverr = rerr;
    end

    // PWM timebase: prescaler then 4095-step count
    if (st_q.pc >= presc - 5'd1) begin
      st_d.pc = 5'd0;
      st_d.bc = (st_q.bc == 12'(PWM_STEPS - 1)) ? 12'h0 : st_q.bc + 12'd1;
    end else begin
      st_d.pc = st_q.pc + 5'd1;
    end

    // Per-channel phase, compare and fault handling
    for (int k = 0; k < 4; k++) begin
      // Channel k lags channel 0 by k stagger delays
      t = {1'b0, st_q.bc} + 13'(PWM_STEPS) - 13'(k) * {1'b0, off};
      if (t >= 13'(PWM_STEPS)) begin
        t = t - 13'(PWM_STEPS);
      end
      pwm[k] = t[11:0] < st_q.duty[k];
      ch_ok = st_q.active & st_q.ctrl.glob_en & st_q.ctrl.ch_en[k];
      case (st_q.fst[k])
        F_RUN: begin
          // Count how long each comparator stays asserted
          st_d.ocnt[k] = (ch_ok & st_q.sy2[7 + k]) ? st_q.ocnt[k] + CW'(1) : '0;
          st_d.scnt[k] = (ch_ok & st_q.sy2[3 + k]) ? st_q.scnt[k] + CW'(1) : '0;
          if (ch_ok & st_q.sy2[7 + k] & (st_q.ocnt[k] == CW'(FLT_CYCLES - 1))) begin
            st_d.fst[k] = F_OFF;
            st_d.kind[k] = 1'b0;
            st_d.ocnt[k] = '0;
          end else if (ch_ok & st_q.sy2[3 + k] & (st_q.scnt[k] == CW'(FLT_CYCLES - 1))) begin
            st_d.fst[k] = F_OFF;
            st_d.kind[k] = 1'b1;
            st_d.ocnt[k] = '0;
          end
        end
        F_OFF: begin
          // Off time so that retries repeat every hiccup period
          st_d.ocnt[k] = st_q.ocnt[k] + CW'(1);
          if (st_q.ocnt[k] == CW'(HICCUP_CYCLES - DET_CYC - 1)) begin
            st_d.fst[k] = F_DET;
            st_d.ocnt[k] = '0;
          end
        end
        F_DET: begin
          // Conduct through the detection window, then decide
          st_d.ocnt[k] = st_q.ocnt[k] + CW'(1);
          if (st_q.ocnt[k] == CW'(DET_CYC - 1)) begin
            st_d.ocnt[k] = '0;
            st_d.scnt[k] = '0;
            if (st_q.kind[k] ? st_q.sy2[3 + k] : st_q.sy2[7 + k]) begin
              st_d.fst[k] = F_OFF;
            end else begin
              st_d.fst[k] = F_RUN;
            end
          end
        end
        default: begin
          st_d.fst[k] = F_RUN;
        end
      endcase
      // Inactive device forgets channel faults
      if (!st_q.active) begin
        st_d.fst[k] = F_RUN;
        st_d.ocnt[k] = '0;
        st_d.scnt[k] = '0;
      end
      // Gate: enables, amplitude, thermal, then PWM or detection window
      st_d.gate[k] = ch_ok & (st_q.amp[k] != 6'h00) & ~st_q.therm
        & ((st_q.fst[k] == F_RUN) ? pwm[k] : (st_q.fst[k] == F_DET));
    end

    // Thermal shutdown with hysteresis
    if (st_q.sy2[2]) begin
      st_d.therm = 1'b1;
    end else if (st_q.sy2[1]) begin
      st_d.therm = 1'b0;
    end

    // Clock-low timeout, one release pulse per low stretch
    st_d.rel = ~st_q.sy2[0] & (st_q.tcnt == CW'(SCL_TO_CYCLES - 1));
    if (st_q.sy2[0]) begin
      st_d.tcnt = '0;
    end else if (st_q.tcnt != CW'(SCL_TO_CYCLES)) begin
      st_d.tcnt = st_q.tcnt + CW'(1);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      st_q.ctrl <= fcld_ctrl_t'(CTRL_RST);
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from state flops
  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign ch_gate = st_q.gate;
  assign ch_amp = st_q.amp;
  assign short_thr = st_q.ctrl.short_threshold_select;
  assign bus_release = st_q.rel;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Helper: write to a low-nibble register
  logic lo_wr;
  assign lo_wr = psel & penable & pwrite & pready & (paddr[7:4] == REG_DLO0[7:4]);

  // Nothing conducts before start-up
  a_inactive_off: assert property (!st_q.active |=> ch_gate == 4'h0)
    else $error("channel on while device inactive");
  // Each channel enable gates only its own sink
  a_chen_off: assert property (1'b1 |=> (ch_gate & ~$past(st_q.ctrl.ch_en)) == 4'h0)
    else $error("disabled channel conducting");
  // Zero amplitude forces the gate off
  a_amp_zero: assert property ((st_q.amp[0] == 6'h00) |=> !ch_gate[0])
    else $error("zero amplitude channel conducting");
  // Low nibble alone never reaches the generator
  a_lo_pending: assert property (lo_wr && !(psel && penable && pwrite
      && paddr[7:4] == REG_DHI0[7:4]) |=> $stable(st_q.duty))
    else $error("low nibble write changed active duty");
  // High byte write applies byte and pending nibble together
  a_dhi_apply: assert property (psel && penable && pwrite && pready && paddr == REG_DHI0
      |=> st_q.duty[0] == {$past(pwdata[7:0]), $past(st_q.dlo[0])})
    else $error("high byte write not applied");
  // Zero duty keeps the channel dark all period
  a_duty_zero: assert property ((st_q.duty[3] == 12'h0 && st_q.fst[3] == F_RUN)
      |=> !ch_gate[3])
    else $error("zero duty channel conducting");
  // Global enable overrides every channel
  a_glob_off: assert property (!st_q.ctrl.glob_en |=> ch_gate == 4'h0)
    else $error("channel on while globally disabled");
  // Prescaler never runs past the selected rate
  a_presc_bound: assert property ($stable(st_q.ctrl.pwm_freq_select)
      |-> st_q.pc < pwm_presc(st_q.ctrl.pwm_freq_select) || $past(st_q.pc) >= st_q.pc)
    else $error("prescaler ran past selected rate");
  // Phase count wraps after its last step
  a_step_range: assert property (st_q.bc < 12'(PWM_STEPS))
    else $error("phase count out of range");
  // Open fault only after a full run of low samples
  a_open_time: assert property ($rose(st_q.fst[0] == F_OFF) && $past(st_q.fst[0]) == F_RUN
      && !st_q.kind[0] |-> $past(st_q.ocnt[0]) == CW'(FLT_CYCLES - 1))
    else $error("open fault declared early");
  // Short fault only after a full run of high samples
  a_short_time: assert property ($rose(st_q.fst[1] == F_OFF) && $past(st_q.fst[1]) == F_RUN
      && st_q.kind[1] |-> $past(st_q.scnt[1]) == CW'(FLT_CYCLES - 1))
    else $error("short fault declared early");
  // Open retry starts a full off time after the last attempt
  a_open_retry: assert property ($rose(st_q.fst[0] == F_DET)
      |-> $past(st_q.ocnt[0]) == CW'(HICCUP_CYCLES - DET_CYC - 1))
    else $error("open retry started off period");
  // Short retry follows the same period
  a_short_retry: assert property ($rose(st_q.fst[1] == F_DET)
      |-> $past(st_q.ocnt[1]) == CW'(HICCUP_CYCLES - DET_CYC - 1))
    else $error("short retry started off period");
  // Open detection window never overruns
  a_det_window: assert property ((st_q.fst[0] == F_DET) |-> st_q.ocnt[0] < CW'(DET_CYC))
    else $error("detection window too long");
  // Short detection window never overruns
  a_short_window: assert property ((st_q.fst[1] == F_DET)
      |-> st_q.ocnt[1] < CW'(DET_CYC))
    else $error("short detection window too long");
  // Thermal shutdown darkens every channel
  a_therm_off: assert property (st_q.therm |=> ch_gate == 4'h0)
    else $error("channel on in thermal shutdown");
  // Release only after the full clock-low count
  a_scl_timeout: assert property (bus_release |-> $past(st_q.tcnt) == CW'(SCL_TO_CYCLES - 1)
      && !$past(st_q.sy2[0]))
    else $error("bus released at wrong time");
  // Release pulse lasts a single cycle
  a_rel_once: assert property (bus_release |=> !bus_release)
    else $error("bus release longer than one cycle");
  // Without stagger, equal channels switch together
  a_stagger_off: assert property (!st_q.ctrl.phase_stagger_enable
      && st_q.duty[0] == st_q.duty[1] && st_q.fst[0] == F_RUN && st_q.fst[1] == F_RUN
      && st_q.ctrl.ch_en[0] && st_q.ctrl.ch_en[1] && st_q.amp[0] != 6'h00
      && st_q.amp[1] != 6'h00 |=> ch_gate[0] == ch_gate[1])
    else $error("channels not aligned without stagger");

endmodule : fcld_top

/* tb/fcld_led_model.sv */
// Model of the LED strings and the serial clock line facing the block
module fcld_led_model
  import fcld_pkg::*;
(
  input wire logic [3:0] open_req,
  input wire logic [3:0] short_req,
  input wire logic scl_hold,
  input wire logic scl_run,
  output fcld_sense_t sense,
  output logic scl
);
  timeunit 1ns;
  timeprecision 1ns;
  logic tog; // Free clock phase
  // Open string leaves sink near ground, short lifts it
  assign sense.open_cmp = open_req;
  assign sense.short_cmp = short_req;
  // Clock toggles only within frames, pulled high between them
  initial tog = 1'b1;
  always #200 tog = scl_run ? ~tog : 1'b1;
  // Stuck host keeps the line low
  assign scl = scl_hold ? 1'b0 : tog;
endmodule : fcld_led_model

/* tb/tb.sv */
// Self-checking bench for the dimming control block
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module tb
  import fcld_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int FLT = 200; // Shortened fault time
  localparam int HIC = 1000; // Shortened retry period
  localparam int SCLT = 300; // Shortened clock-low timeout
  localparam int PRE = (CLK_HZ + F_SEL3_HZ * PWM_STEPS / 2) / (F_SEL3_HZ * PWM_STEPS);
  localparam int OFF = (STAGGER_CYC + PRE / 2) / PRE; // Stagger in steps
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, err, bus_release, scl;
  logic uvlo_ok = 0, en_pin = 1, temp_hot = 0, temp_cool = 1;
  logic [3:0] open_req = 0, short_req = 0, ch_gate;
  logic scl_hold = 0, scl_run = 0;
  logic [1:0] short_thr, o;
  logic [3:0][5:0] ch_amp;
  fcld_sense_t sense;
  int failures = 0, samples_checked = 0, n, t, h0, r1, rel;
  // Clock and release-pulse counter
  always #25 pclk = ~pclk;
  always @(posedge pclk) rel <= rel + int'(bus_release === 1'b1);
  fcld_top #(.FLT_CYCLES(FLT), .HICCUP_CYCLES(HIC), .SCL_TO_CYCLES(SCLT)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .uvlo_ok(uvlo_ok), .en_pin(en_pin), .sense(sense), .temp_hot(temp_hot),
    .temp_cool(temp_cool), .scl_in(scl), .ch_gate(ch_gate), .ch_amp(ch_amp),
    .short_thr(short_thr), .bus_release(bus_release));
  fcld_led_model far_u (.open_req(open_req), .short_req(short_req), .scl_hold(scl_hold),
    .scl_run(scl_run), .sense(sense), .scl(scl));
  // One APB transfer, held until pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  // Wait for a gate level, cycles in n
  task automatic wt(input int k, input logic v, input int lim);
    n = 0;
    while (ch_gate[k] !== v && n < lim) begin @(posedge pclk); n++; end
    if (n >= lim) failures++;
  endtask : wt
  task automatic summarize();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  // Watchdog
  initial begin
    repeat (100000) @(posedge pclk);
    failures++;
    summarize();
  end
  // Test sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    xfer(0, REG_CTRL, 0); `CHK(rd[11:0], CTRL_RST)
    xfer(0, 8'hfc, 0); `CHK(err, 1'b1)
    for (int k = 0; k < 4; k++) begin
      xfer(1, 8'(REG_AMP0 + 4 * k), 32'(6'h21 + k));
      xfer(1, 8'(REG_DHI0 + 4 * k), (k == 3) ? 32'h0 : 32'h10);
    end
    xfer(1, REG_DLO0, 32'h5);
    xfer(0, REG_DHI0, 0); `CHK(rd[7:0], 8'h10)
    xfer(1, REG_CTRL, 32'h00c);
    repeat (200) @(posedge pclk);
    xfer(1, REG_CTRL, 32'hb0f);
    repeat (100) @(posedge pclk);
    `CHK(ch_gate, 4'h0)
    `CHK(ch_amp[2], 6'h23)
    $display("test reset and setup done");
    uvlo_ok <= 1'b1;
    wt(0, 1, 70000);
    wt(0, 0, 70000);
    wt(0, 1, 70000);
    h0 = 0; r1 = -1; o = 0;
    for (int i = 0; i < 5000; i++) begin
      h0 += int'(ch_gate[0] === 1'b1);
      if (r1 < 0 && ch_gate[1] === 1'b1) r1 = i;
      o |= ch_gate[3:2];
      @(posedge pclk);
    end
    `CHK(h0, 256 * PRE)
    `CHK(r1, OFF * PRE)
    `CHK(o[0], 1'b0)
    `CHK(o[1], 1'b0)
    xfer(1, REG_CTRL, 32'hb0c);
    repeat (10) @(posedge pclk);
    `CHK(ch_gate, 4'h0)
    $display("test dimming done");
    xfer(1, REG_CTRL, 32'hb3d);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) open_req[0] <= 1'b1; else short_req[1] <= 1'b1;
      repeat (FLT + 20) @(posedge pclk);
      xfer(0, REG_STAT, 0); `CHK(rd[k * 5], 1'b1)
      wt(k, 1, HIC);
      wt(k, 0, HIC); `CHK(n, DET_CYC)
      wt(k, 1, HIC); `CHK(n, HIC - DET_CYC)
      open_req <= 4'h0; short_req <= 4'h0;
      repeat (2 * HIC) @(posedge pclk);
      xfer(0, REG_STAT, 0); `CHK(rd[k * 5], 1'b0)
    end
    `CHK(short_thr, 2'h3)
    $display("test faults done");
    temp_hot <= 1'b1; temp_cool <= 1'b0;
    repeat (10) @(posedge pclk);
    `CHK(ch_gate, 4'h0)
    temp_hot <= 1'b0;
    xfer(0, REG_STAT, 0); `CHK(rd[8], 1'b1)
    temp_cool <= 1'b1;
    repeat (10) @(posedge pclk);
    xfer(0, REG_STAT, 0); `CHK(rd[8], 1'b0)
    $display("test thermal done");
    scl_run <= 1'b1;
    repeat (2 * SCLT) @(posedge pclk);
    `CHK(rel, 0)
    scl_run <= 1'b0; scl_hold <= 1'b1;
    repeat (SCLT - 10) @(posedge pclk);
    `CHK(rel, 0)
    repeat (60) @(posedge pclk);
    `CHK(rel, 1)
    repeat (SCLT) @(posedge pclk);
    `CHK(rel, 1)
    $display("test bus timeout done");
    summarize();
  end
endmodule : tb
